// ### rtl/angle_params.svh
// constants for the redundant angle compute core
// assumes a 25 MHz core clock and 16-bit angles (65536 counts = one turn)
`ifndef ANGLE_PARAMS_SVH
`define ANGLE_PARAMS_SVH
`define PLATE_W 14
`define CLK_PERIOD_NS 40
`define REFRESH_NS 2000
`define BW_SEL_DEFAULT 3'h2
`define BW_SEL_MAX 3'h4
`define FILT_SHIFT_BASE 3'h5
`define FILT_FRAC 6
`define SQRT3_HALF_Q10 11'h377
`define INV_SQRT3_Q10 11'h24f
`define Q_SHIFT 10
`define DEG60 16'h2aab
`define DEG120 16'h5555
`define DEG180 16'h8000
`define LIN_SHIFT 4
`define CORDIC_STEPS 16
`define MISMATCH_DEFAULT 16'h00b6
`define ANGLE_STATUS_ADDR 8'h0c
`define ANGLE_VALID_BIT 0
`define ERR_BIT_LSB 1
`endif

// ### rtl/angle_pkg.sv
// types shared by the angle core and its surroundings
// assumes angle_params.svh is on the include path
`include "angle_params.svh"
package angle_pkg;
    typedef struct packed {
        logic signed [`PLATE_W-1:0] p6;
        logic signed [`PLATE_W-1:0] p5;
        logic signed [`PLATE_W-1:0] p4;
        logic signed [`PLATE_W-1:0] p3;
        logic signed [`PLATE_W-1:0] p2;
        logic signed [`PLATE_W-1:0] p1;
    } plate_field_sample_type;
    typedef struct packed {
        logic [15:0] zero_offset;
        logic [2:0] filter_bandwidth_select;
        logic [2:0] diag_enable;
        logic [15:0][7:0] lin_table;
    } nvm_config_type;
    typedef struct packed {
        logic [15:0] redundant_angle_ca;
        logic [15:0] redundant_angle_bc;
        logic [15:0] redundant_angle_ab;
        logic [15:0] main_angle;
    } angles_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DONE = 2'b11
    } cordic_state_type;
endpackage

// ### rtl/redundant_angle_compute.sv
// redundant angle compute core: main angle plus three pair angles
// assumes plate samples come from converters on the same clock
// Summary of operation
// (R1) main angle is atan2 of sqrt3/2*(B+C) over A+(B-C)/2
// (R2) channel A is plate1-plate4, B plate2-plate5, C plate3-plate6
// (R3) three redundant angles from channel pairs AB, BC and CA
// (R4) compare main with each redundant angle every cycle; mismatch means safe
// (R5) a fresh angle result every 2 us
// (R6) the angle value is 16 bits wide
// (R7) latency follows the filter bandwidth, 90 down to 15 us
// (R8) four independent results computed in parallel
// (R9) main uses six plates, each redundant path only four
// (R10) zero offset, filter, linearization, diagnostics come from nvm config
// (R11) 3-bit bandwidth select, 000..100, default 010
// (R12) valid flag set once an angle exists and no error is present
// (R13) mismatch threshold is a parameter; sticky flag per redundant angle
// (R14) each redundant angle uses a parameterised arctangent block
`timescale 1ns/1ps
`default_nettype none
`include "angle_params.svh"

module angle_atan2
    import angle_pkg::*;
#(
    parameter int DW = 19
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic start,
    input wire logic signed [DW-1:0] x_in,
    input wire logic signed [DW-1:0] y_in,
    output logic done,
    output logic [15:0] angle
);
    cordic_state_type state;
    logic signed [DW-1:0] xr;
    logic signed [DW-1:0] yr;
    logic [3:0] step;
    logic [15:0] next_z;
    logic signed [DW-1:0] next_x;
    logic signed [DW-1:0] next_y;
    logic y_neg;
    logic last_step;

    // narrower operands lose the angle in rounding
    if (DW < 8) begin : g_bad_width
        $error("angle_atan2: DW too small");
    end

    // arctangent of 2^-i in 16-bit turn units
    function automatic logic [15:0] atan_step(input logic [3:0] i);
        unique case (i)
            4'h0: atan_step = 16'h2000;
            4'h1: atan_step = 16'h12e4;
            4'h2: atan_step = 16'h09fb;
            4'h3: atan_step = 16'h0511;
            4'h4: atan_step = 16'h028b;
            4'h5: atan_step = 16'h0146;
            4'h6: atan_step = 16'h00a3;
            4'h7: atan_step = 16'h0051;
            4'h8: atan_step = 16'h0029;
            4'h9: atan_step = 16'h0014;
            4'ha: atan_step = 16'h000a;
            4'hb: atan_step = 16'h0005;
            4'hc: atan_step = 16'h0003;
            4'hd: atan_step = 16'h0001;
            4'he: atan_step = 16'h0001;
            4'hf: atan_step = 16'h0000;
        endcase
    endfunction

    // vectoring rotation drives y toward zero, z gathers the angle
    assign y_neg = yr[DW-1];
    assign next_x = y_neg ? xr - (yr >>> step) : xr + (yr >>> step);
    assign next_y = y_neg ? yr + (xr >>> step) : yr - (xr >>> step);
    assign next_z = y_neg ? angle - atan_step(step)
                          : angle + atan_step(step);
    assign last_step = (step == 4'(`CORDIC_STEPS - 1));
    assign done = (state == ST_DONE);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            xr <= '0;
            yr <= '0;
            angle <= 16'h0000;
            step <= 4'h0;
        end else if (ce) begin
            unique case (state)
                ST_IDLE: begin
                    if (start) begin
                        // fold the left half plane over; cordic covers +-90
                        xr <= x_in[DW-1] ? -x_in : x_in;
                        yr <= x_in[DW-1] ? -y_in : y_in;
                        angle <= x_in[DW-1] ? `DEG180 : 16'h0000;
                        step <= 4'h0;
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    xr <= next_x;
                    yr <= next_y;
                    angle <= next_z;
                    step <= step + 4'h1;
                    if (last_step) state <= ST_DONE;
                end
                ST_DONE: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // angle_atan2

module redundant_angle_compute
    import angle_pkg::*;
#(
    parameter logic [15:0] MISMATCH_LIMIT = `MISMATCH_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire plate_field_sample_type plate_field_sample,
    input wire nvm_config_type nvm_cfg,
    input wire logic err_clear,
    output angles_type angles,
    output logic angle_update,
    output logic angle_valid_flag,
    output logic [2:0] mismatch_err,
    output logic safe_state,
    output logic [15:0] angle_status
);
    localparam int CW = `PLATE_W + 1;
    localparam int AW = CW + `FILT_FRAC;
    localparam int DW = `PLATE_W + 5;
    localparam int PW = DW + 12;
    localparam int REFRESH_CYCLES = `REFRESH_NS / `CLK_PERIOD_NS;
    localparam int RW = $clog2(REFRESH_CYCLES);

    if (MISMATCH_LIMIT == 16'h0000 || MISMATCH_LIMIT[15]) begin : g_bad_limit
        $error("redundant_angle_compute: bad MISMATCH_LIMIT");
    end
    if (REFRESH_CYCLES < `CORDIC_STEPS + 3) begin : g_bad_refresh
        $error("redundant_angle_compute: refresh shorter than solve");
    end

    // differential channels from opposite plates
    logic signed [CW-1:0] diff_channel_a;
    logic signed [CW-1:0] diff_channel_b;
    logic signed [CW-1:0] diff_channel_c;
    assign diff_channel_a = CW'(plate_field_sample.p1)
                          - CW'(plate_field_sample.p4); // [R2]
    assign diff_channel_b = CW'(plate_field_sample.p2)
                          - CW'(plate_field_sample.p5); // [R2]
    assign diff_channel_c = CW'(plate_field_sample.p3)
                          - CW'(plate_field_sample.p6); // [R2]

    // refresh timer
    logic [RW-1:0] refresh_cnt;
    logic refresh_tick;
    logic start_solve;
    assign refresh_tick = (refresh_cnt == RW'(REFRESH_CYCLES - 1)); // [R5]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) refresh_cnt <= '0;
        else if (ce) refresh_cnt <= refresh_tick ? '0 : refresh_cnt + 1'b1;
    end

    // first-order smoothing per channel, coefficient 2^-shift
    logic bw_legal;
    logic [2:0] bw_eff;
    logic [2:0] filt_shift;
    assign bw_legal = (nvm_cfg.filter_bandwidth_select <= `BW_SEL_MAX);
    assign bw_eff = bw_legal ? nvm_cfg.filter_bandwidth_select
                             : `BW_SEL_DEFAULT; // [R11]
    // lower bandwidth means a longer time constant, hence longer latency
    assign filt_shift = `FILT_SHIFT_BASE - bw_eff; // [R7] [R10]

    logic signed [CW-1:0] chan_raw [3];
    logic signed [AW-1:0] acc [3];
    logic signed [CW-1:0] chan_f [3];
    assign chan_raw[0] = diff_channel_a;
    assign chan_raw[1] = diff_channel_b;
    assign chan_raw[2] = diff_channel_c;

    for (genvar g = 0; g < 3; g++) begin : g_filt
        logic signed [AW:0] err_term;
        assign err_term = (AW+1)'(chan_raw[g]) * (AW+1)'(2 ** `FILT_FRAC)
                        - (AW+1)'(acc[g]);
        assign chan_f[g] = CW'(acc[g] >>> `FILT_FRAC);
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) acc[g] <= '0;
            else if (ce && refresh_tick)
                acc[g] <= acc[g] + AW'(err_term >>> filt_shift); // [R10]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) start_solve <= 1'b0;
        else if (ce) start_solve <= refresh_tick;
    end

    // arctangent operands; path 0 main, 1 ab, 2 bc, 3 ca
    logic signed [DW-1:0] fa;
    logic signed [DW-1:0] fb;
    logic signed [DW-1:0] fc;
    logic signed [PW-1:0] prod_main;
    logic signed [PW-1:0] prod_ab;
    logic signed [PW-1:0] prod_bc;
    logic signed [PW-1:0] prod_ca;
    logic signed [DW-1:0] op_x [4];
    logic signed [DW-1:0] op_y [4];
    assign fa = DW'(chan_f[0]);
    assign fb = DW'(chan_f[1]);
    assign fc = DW'(chan_f[2]);

    // main uses all six plates through A, B and C
    assign prod_main = PW'(fb + fc) * PW'($signed({1'b0, `SQRT3_HALF_Q10}));
    assign op_x[0] = fa + ((fb - fc) >>> 1); // [R1] [R9]
    assign op_y[0] = DW'(prod_main >>> `Q_SHIFT); // [R1]

    // a pair at 60 deg spacing: x = P, y = (2Q - P)/sqrt3, then rotate back
    assign prod_ab = PW'(2 * fb - fa) * PW'($signed({1'b0, `INV_SQRT3_Q10}));
    assign prod_bc = PW'(2 * fc - fb) * PW'($signed({1'b0, `INV_SQRT3_Q10}));
    assign prod_ca = PW'(-2 * fa - fc) * PW'($signed({1'b0, `INV_SQRT3_Q10}));
    assign op_x[1] = fa; // [R3] [R9]
    assign op_y[1] = DW'(prod_ab >>> `Q_SHIFT); // [R3]
    assign op_x[2] = fb; // [R3] [R9]
    assign op_y[2] = DW'(prod_bc >>> `Q_SHIFT); // [R3]
    assign op_x[3] = fc; // [R3] [R9]
    assign op_y[3] = DW'(prod_ca >>> `Q_SHIFT); // [R3]

    logic [3:0] solve_done;
    logic [15:0] raw_angle [4];
    logic [15:0] frame_offset [4];
    assign frame_offset[0] = 16'h0000;
    assign frame_offset[1] = 16'h0000;
    assign frame_offset[2] = `DEG60;
    assign frame_offset[3] = `DEG120;

    // four solvers run side by side so every path has its own result
    for (genvar p = 0; p < 4; p++) begin : g_path
        angle_atan2 #(
            .DW(DW)
        ) u_atan (
            .clk(clk),
            .rst_n(rst_n),
            .ce(ce),
            .start(start_solve),
            .x_in(op_x[p]),
            .y_in(op_y[p]),
            .done(solve_done[p]),
            .angle(raw_angle[p])
        ); // [R8] [R14]
    end

    // zero offset and nearest-segment linearization, no interpolation
    function automatic logic [15:0] correct(input logic [15:0] a,
                                            input logic [15:0] zero,
                                            input logic [15:0][7:0] lin);
        logic [7:0] c;
        c = lin[a[15:12]];
        correct = a - zero + {{(8 - `LIN_SHIFT){c[7]}}, c, `LIN_SHIFT'(0)};
    endfunction

    logic all_done;
    logic [15:0] next_angle [4];
    assign all_done = &solve_done;
    for (genvar p = 0; p < 4; p++) begin : g_corr
        assign next_angle[p] = correct(raw_angle[p] + frame_offset[p],
                                       nvm_cfg.zero_offset,
                                       nvm_cfg.lin_table); // [R10]
    end

    logic first_done;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            angles <= '0;
            angle_update <= 1'b0;
            first_done <= 1'b0;
        end else if (ce) begin
            angle_update <= all_done; // [R5]
            if (all_done) begin
                angles.main_angle <= next_angle[0]; // [R6]
                angles.redundant_angle_ab <= next_angle[1]; // [R8]
                angles.redundant_angle_bc <= next_angle[2];
                angles.redundant_angle_ca <= next_angle[3];
                first_done <= 1'b1;
            end
        end
    end

    // continuous cross-check; wraparound handled by signed difference
    logic [15:0] red_angle [3];
    logic [2:0] mismatch_set;
    assign red_angle[0] = angles.redundant_angle_ab;
    assign red_angle[1] = angles.redundant_angle_bc;
    assign red_angle[2] = angles.redundant_angle_ca;

    for (genvar r = 0; r < 3; r++) begin : g_cmp
        logic signed [15:0] delta;
        logic [15:0] delta_mag;
        assign delta = $signed(angles.main_angle - red_angle[r]);
        assign delta_mag = delta[15] ? 16'(-delta) : 16'(delta);
        assign mismatch_set[r] = first_done && nvm_cfg.diag_enable[r]
                              && (delta_mag > MISMATCH_LIMIT); // [R4] [R13]
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) mismatch_err <= 3'h0;
        else if (ce)
            mismatch_err <= (mismatch_err & {3{~err_clear}})
                          | mismatch_set; // [R13]
    end

    assign safe_state = |mismatch_err; // [R4]
    assign angle_valid_flag = first_done && !safe_state; // [R12]

    always_comb begin
        angle_status = 16'h0000;
        angle_status[`ANGLE_VALID_BIT] = angle_valid_flag; // [R12]
        angle_status[`ERR_BIT_LSB +: 3] = mismatch_err;
    end
endmodule // redundant_angle_compute
`default_nettype wire

// ### verification/angle_core_assertions.sv
// checker on the angle core ports
// assumes one clock domain and a bind from the bench
`timescale 1ns/1ps
`default_nettype none
module angle_core_assertions
    import angle_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire nvm_config_type nvm_cfg,
    input wire logic err_clear,
    input wire angles_type angles,
    input wire logic angle_update,
    input wire logic angle_valid_flag,
    input wire logic [2:0] mismatch_err,
    input wire logic safe_state,
    input wire logic [15:0] angle_status
);
    wire logic [2:0] diag = nvm_cfg.diag_enable;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence quiet_s;
        (!angle_update) [*8];
    endsequence
    sequence fresh_s;
        angle_update && mismatch_err == 3'h0;
    endsequence
    // a stall may hold the pulse high, so stalled attempts are dropped
    AST_UPDATE_PULSE: assert property (disable iff (!rst_n || !ce)
        angle_update |=> quiet_s)
        else $error("angle update is not a lone pulse");
    // a stall aborts the attempt, the period counts running cycles only
    AST_REFRESH_PERIOD: assert property (disable iff (!rst_n || !ce)
        angle_update |-> ##50 angle_update)
        else $error("refresh period is not 50 cycles");
    AST_ANGLES_HOLD: assert property ($changed(angles) |-> angle_update)
        else $error("angles moved without an update");
    AST_SAFE_STATE: assert property (safe_state == (|mismatch_err))
        else $error("safe state differs from error bits");
    AST_STATUS_MAP: assert property (
        angle_status == {12'h000, mismatch_err, angle_valid_flag})
        else $error("status word layout wrong");
    AST_VALID_NO_ERR: assert property (
        angle_valid_flag |-> mismatch_err == 3'h0)
        else $error("valid flag with an error present");
    AST_VALID_FRESH: assert property (fresh_s |-> angle_valid_flag)
        else $error("fresh angle without valid flag");
    AST_ERR_STICKY: assert property (
        |($past(mismatch_err) & ~mismatch_err) |-> $past(err_clear))
        else $error("error bit dropped without clear");
    AST_ERR_MASK: assert property (
        (mismatch_err & ~$past(mismatch_err) & ~$past(diag)) == 3'h0)
        else $error("masked error bit was set");
endmodule // angle_core_assertions
`default_nettype wire

// ### verification/plate_front_end.sv
// front end model: six plate readings for one magnet angle
// assumes the core samples the plates only on its refresh tick
`timescale 1ns/1ps
`default_nettype none
module plate_front_end
    import angle_pkg::*;
(
    input wire logic [8:0] deg,
    input wire logic signed [13:0] stray,
    input wire logic drop_c,
    output plate_field_sample_type plates
);
    real th;
    function automatic logic signed [13:0] fld(input real ph);
        return 14'($rtoi(1500.0 * $cos(ph)));
    endfunction
    // opposite plates see opposite field, stray is common mode
    // drop_c kills the third pair so main and the pairs with c go wrong
    // always_comb also runs at time zero, so the plates never start unknown
    always_comb begin
        th = deg * 3.14159265 / 180.0;
        plates.p1 = fld(th) + stray;
        plates.p4 = -fld(th) + stray;
        plates.p2 = fld(th - 1.04719755) + stray;
        plates.p5 = -fld(th - 1.04719755) + stray;
        plates.p3 = drop_c ? stray : fld(th - 2.0943951) + stray;
        plates.p6 = drop_c ? stray : -fld(th - 2.0943951) + stray;
    end
endmodule // plate_front_end
`default_nettype wire

// ### verification/tb_redundant_angle_compute.sv
// bench for the angle core, plates come from the front end model
// assumes a 25 MHz clock and the default mismatch limit
`timescale 1ns/1ps
`default_nettype none
`include "angle_params.svh"
`define CHK(nm, e, g) begin checked++; if ((e) !== (g)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_redundant_angle_compute import angle_pkg::*; ();
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic err_clear = 1'b0;
    logic drop_c = 1'b0;
    logic [8:0] deg = 9'h000;
    logic signed [13:0] stray = 14'sh0000;
    nvm_config_type cfg = '0;
    plate_field_sample_type plates;
    angles_type angles;
    logic upd;
    logic valid;
    logic safe;
    logic [2:0] err;
    logic [15:0] status;
    int bad_count = 0;
    int checked = 0;
    always #20 clk = ~clk;
    plate_front_end fe (.deg(deg), .stray(stray), .drop_c(drop_c),
        .plates(plates));
    redundant_angle_compute uut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .plate_field_sample(plates), .nvm_cfg(cfg), .err_clear(err_clear),
        .angles(angles), .angle_update(upd), .angle_valid_flag(valid),
        .mismatch_err(err), .safe_state(safe), .angle_status(status));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_upd(output int n);
        n = 0;
        do begin
            tick(1);
            n++;
        end while (upd !== 1'b1 && n < 200);
    endtask
    function automatic logic [15:0] code(input int dg);
        return 16'((dg * 65536 + 180) / 360);
    endfunction
    // 0x40 counts of slack covers solver rounding and filter residue
    function automatic logic near(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        d = a - e;
        return (d < 16'h0040) || (d > 16'hffc0);
    endfunction
    task automatic t_reset();
        int n;
        tick(16);
        `CHK("reset status", 16'h0000, status)
        `CHK("reset main", 16'h0000, angles.main_angle)
        rst_n = 1'b1;
        wait_upd(n);
        `CHK("first update", 68, n)
        wait_upd(n);
        `CHK("period", 50, n)
    endtask
    task automatic t_angles();
        int dl[5] = '{0, 45, 100, 200, 330};
        logic [15:0] e;
        foreach (dl[i]) begin
            deg = 9'(dl[i]);
            e = code(dl[i]);
            tick(3000);
            `CHK("main", 1'b1, near(angles.main_angle, e))
            `CHK("ab", 1'b1, near(angles.redundant_angle_ab, e))
            `CHK("bc", 1'b1, near(angles.redundant_angle_bc, e))
            `CHK("ca", 1'b1, near(angles.redundant_angle_ca, e))
            `CHK("valid", 1'b1, valid)
        end
    endtask
    task automatic t_stray();
        stray = 14'sd2000;
        tick(3000);
        `CHK("stray main", 1'b1, near(angles.main_angle, code(330)))
        `CHK("stray ab", 1'b1, near(angles.redundant_angle_ab, code(330)))
        stray = 14'sh0000;
    endtask
    task automatic t_zero();
        logic [15:0] e;
        cfg.zero_offset = `DEG60;
        deg = 9'd100;
        tick(3000);
        e = code(100) - `DEG60;
        `CHK("zero main", 1'b1, near(angles.main_angle, e))
        // segment 4 holds 100 degrees; -16 steps of 16 counts pull it back
        cfg.lin_table[4] = 8'hf0;
        tick(60);
        e = code(100) - `DEG60 - 16'h0100;
        `CHK("lin main", 1'b1, near(angles.main_angle, e))
        cfg.lin_table[4] = 8'h00;
        cfg.zero_offset = 16'h0000;
    endtask
    task automatic t_bw();
        // only a 50 kHz filter settles a 90 degree step in ten refreshes
        // an illegal select falls back to the slower 12.5 kHz default
        cfg.filter_bandwidth_select = 3'h7;
        deg = 9'd190;
        tick(500);
        `CHK("slow bw", 1'b0, near(angles.main_angle, code(190)))
        cfg.filter_bandwidth_select = 3'h4;
        deg = 9'd100;
        tick(500);
        `CHK("fast bw", 1'b1, near(angles.main_angle, code(100)))
        cfg.filter_bandwidth_select = 3'h2;
    endtask
    task automatic t_mismatch();
        int n;
        deg = 9'd0;
        tick(3000);
        cfg.diag_enable = 3'h1;
        err_clear = 1'b1;
        tick(1);
        err_clear = 1'b0;
        tick(2);
        `CHK("err idle", 3'h0, err)
        drop_c = 1'b1;
        tick(3000);
        `CHK("err ab only", 3'h1, err)
        `CHK("safe", 1'b1, safe)
        `CHK("status err", 16'h0002, status)
        err_clear = 1'b1;
        tick(2);
        `CHK("set wins", 3'h1, err)
        err_clear = 1'b0;
        drop_c = 1'b0;
        tick(3000);
        `CHK("sticky", 3'h1, err)
        err_clear = 1'b1;
        tick(1);
        err_clear = 1'b0;
        wait_upd(n);
        `CHK("cleared", 3'h0, err)
        `CHK("valid back", 1'b1, valid)
    endtask
    task automatic t_stall();
        int n;
        angles_type held;
        wait_upd(n);
        tick(1);
        ce = 1'b0;
        held = angles;
        // a new field during the stall must not reach the angles
        deg = 9'd90;
        tick(200);
        `CHK("frozen", held, angles)
        ce = 1'b1;
        wait_upd(n);
        `CHK("resume", 49, n)
    endtask
    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #2400000;
        bad_count++;
        finish_test();
    end
    initial begin
        cfg.filter_bandwidth_select = 3'h2;
        t_reset();
        t_angles();
        t_stray();
        t_zero();
        t_bw();
        t_mismatch();
        t_stall();
        finish_test();
    end
endmodule // tb_redundant_angle_compute
bind redundant_angle_compute angle_core_assertions chk (.clk(clk),
    .rst_n(rst_n), .ce(ce), .nvm_cfg(nvm_cfg), .err_clear(err_clear),
    .angles(angles), .angle_update(angle_update),
    .angle_valid_flag(angle_valid_flag), .mismatch_err(mismatch_err),
    .safe_state(safe_state), .angle_status(angle_status));
`default_nettype wire
